// >>> core/asb_unit.sv
// Purpose: Executes arithmetic shifts and conditional relative branches
// Assumes: Software loads instruction, operand, count register and PC, then sets go
// Notes: Avalon-MM slave; every access is answered after one wait state
`timescale 1ns/1ps
module asb_unit
  import asb_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Execution status
  output logic busy,
  output logic done
);
  typedef struct packed {
    asb_state_t st;
    logic [15:0] insn;
    logic [31:0] opnd;
    logic [31:0] cnt_reg;
    logic [23:0] pc;
    asb_flags_t flags;
    logic [4:0] steps;
    logic [5:0] cycles;
    logic vsticky;
    logic taken;
    logic [31:0] readdata;
    logic waitreq;
    logic busy;
    logic done;
  } asb_regs_t;

  asb_regs_t r;
  asb_regs_t next_r;

  logic [1:0] size;
  logic left;
  logic is_shift;
  logic is_branch;
  logic [31:0] step_res;
  logic step_c;
  logic step_sc;
  logic br_taken;
  logic [31:0] step2_res;
  logic step2_c;
  logic step2_sc;
  logic [4:0] remaining;
  logic [31:0] picked;
  logic [4:0] count;
  logic [31:0] masked;
  logic [7:0] disp;

  assign size = r.insn[11:10];
  assign left = (r.insn[9:8] == SHIFT_LEFT_LOW);
  assign is_shift = (r.insn[15:12] == OP_SHIFT_REG) || (r.insn[15:12] == OP_SHIFT_IMM);
  assign is_branch = (r.insn[15:12] == OP_BRANCH);
  assign disp = r.insn[7:0];

  asb_shift_step u_step (
    .val(r.opnd),
    .size(size),
    .left(left),
    .res(step_res),
    .cout(step_c),
    .sign_chg(step_sc)
  );

  // Second stage retires a second bit each clock, so long shifts stay inside the cycle budget
  asb_shift_step u_step2 (
    .val(step_res),
    .size(size),
    .left(left),
    .res(step2_res),
    .cout(step2_c),
    .sign_chg(step2_sc)
  );

  asb_branch_cond u_cond (
    .cond(r.insn[11:8]),
    .flags(r.flags),
    .taken(br_taken),
    .known()
  );

  always_comb begin
    // Count source: register uses low five bits only, immediate width follows size
    if (r.insn[15:12] == OP_SHIFT_REG) begin
      count = r.cnt_reg[4:0];
    end else if (size == SZ_DWORD) begin
      count = r.insn[4:0];
    end else begin
      count = {1'b0, r.insn[3:0]};
    end
    remaining = count - r.steps;
    picked = (remaining == 5'h01) ? step_res : step2_res;
    case (size)
      SZ_BYTE: masked = {24'h000000, picked[7:0]};
      SZ_WORD: masked = {16'h0000, picked[15:0]};
      default: masked = picked;
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.waitreq = 1'b1;
    // One wait state on every access lets waitrequest come straight from a register
    if ((avs_read || avs_write) && r.waitreq) begin
      next_r.waitreq = 1'b0;
      if (avs_read) begin
        case (avs_address)
          OFS_STAT: next_r.readdata = {12'h000, r.flags, 14'h0, r.taken, r.busy};
          OFS_INSN: next_r.readdata = {8'h00, r.pc};
          OFS_OPND: next_r.readdata = r.opnd;
          OFS_CNT: next_r.readdata = r.cnt_reg;
          default: next_r.readdata = 32'h0000_0000;
        endcase
      end
    end
    // Writes land at the answering edge and are ignored while an instruction runs
    if (avs_write && !r.waitreq && !r.busy) begin
      case (avs_address)
        OFS_CTRL: begin
          if (avs_writedata[CTRL_GO_BIT]) begin
            next_r.busy = 1'b1;
            next_r.st = ST_SHIFT;
            next_r.steps = 5'h00;
            next_r.vsticky = 1'b0;
            next_r.cycles = 6'h00;
          end
          if (avs_byteenable[2]) begin
            next_r.flags = avs_writedata[19:16];
          end
        end
        OFS_INSN: begin
          if (avs_byteenable[0]) next_r.insn[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) next_r.insn[15:8] = avs_writedata[15:8];
          if (avs_byteenable[2]) next_r.pc[7:0] = avs_writedata[23:16];
          if (avs_byteenable[3]) next_r.pc[15:8] = avs_writedata[31:24];
        end
        OFS_OPND: next_r.opnd = avs_writedata;
        OFS_CNT: next_r.cnt_reg = avs_writedata;
        default: ;
      endcase
    end
    case (r.st)
      ST_IDLE: ;
      ST_SHIFT: begin
        next_r.cycles = r.cycles + 6'h01;
        if (is_branch) begin
          next_r.pc = r.pc + PC_STEP;
          next_r.taken = br_taken;
          if (br_taken) begin
            // Target spans +254 to -256 bytes, forced to a word boundary
            next_r.pc = (r.pc + PC_STEP + {{15{disp[7]}}, disp, 1'b0}) & 24'hFFFFFE;
          end
          next_r.st = ST_WAIT;
        end else if (is_shift && (r.steps != count)) begin
          // Two bits per clock, one when a single bit is left
          next_r.opnd = masked;
          if (remaining == 5'h01) begin
            next_r.flags.c = step_c;
            next_r.vsticky = r.vsticky | step_sc;
            next_r.steps = r.steps + 5'h01;
          end else begin
            next_r.flags.c = step2_c;
            next_r.vsticky = r.vsticky | step_sc | step2_sc;
            next_r.steps = r.steps + 5'h02;
          end
        end else begin
          if (is_shift) begin
            // Zero count leaves operand alone but still refreshes N and Z
            if (left) next_r.flags.v = r.vsticky;
            case (size)
              SZ_BYTE: next_r.flags.n = r.opnd[7];
              SZ_WORD: next_r.flags.n = r.opnd[15];
              default: next_r.flags.n = r.opnd[31];
            endcase
            next_r.flags.z = (r.opnd == 32'h0000_0000);
            if (count == 5'h00) next_r.flags.c = r.flags.c;
          end
          next_r.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_r.cycles = r.cycles + 6'h01;
        // Total cost padded out to the documented clocks, flags untouched for branches
        if (r.cycles + 6'h01 >= target_cycles(r.taken)) begin
          next_r.st = ST_IDLE;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  function automatic logic [5:0] target_cycles(input logic tk);
    logic [5:0] base;
    base = (size == SZ_DWORD) ? CYC_SHIFT_DW_BASE : CYC_SHIFT_BASE;
    if (is_branch) begin
      target_cycles = tk ? CYC_BR_TAKEN : CYC_BR_NOT;
    end else if (!is_shift) begin
      target_cycles = CYC_BR_NOT;
    end else begin
      target_cycles = base + {2'b00, count[4:1]};
    end
  endfunction

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.opnd <= RESET_OPND;
      r.pc <= RESET_PC;
      r.waitreq <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata = r.readdata;
  assign avs_waitrequest = r.waitreq;
  assign busy = r.busy;
  assign done = r.done;
endmodule // asb_unit

// >>> include/asb_pkg.sv
// Purpose: Shared constants and types for the arithmetic shift and conditional branch unit
// Assumes: Single 125 MHz core clock, instructions presented as two bytes
// Notes: Register map is a small control/status window on Avalon-MM
// Behaviour
// - Left shift zero-fills, msb goes to carry
// - Any sign change sets overflow, stays set
// - Left shift clears overflow if sign never changed
// - Left shift updates carry, overflow, sign, zero
// - Base 4 (dword 6) clocks plus half count
// - Size field 00 byte, 10 word, 11 dword
// - Right shift: low bit to carry, sign refill
// - Zero count leaves operand unshifted
// - Register count uses low five bits only
// - Register count truncated; immediate counted down to zero
// - Immediate count four bits, five for dword
// - Count register left unchanged
// - Right shift keeps overflow unchanged
// - PC plus two, taken adds twice displacement
// - Target within +254/-256, word aligned
// - Carry-clear branch taken when carry zero
// - Carry-set branch taken when carry one
// - Zero branch taken when zero flag one
// - Above-unsigned taken when zero and carry both clear
// - Signed ge taken when sign xor overflow zero
// - Signed gt: (zero or sign) xor overflow clear
// - Branch six clocks taken, three not; flags kept
package asb_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_INSN = 4'h4;
  localparam logic [3:0] OFS_OPND = 4'h8;
  localparam logic [3:0] OFS_CNT = 4'hC;
  localparam logic [3:0] OFS_STAT = 4'h0;
  // Control and status register bit positions
  localparam int CTRL_GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  // Flag order inside the flag field
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 3;
  // Opcode patterns
  localparam logic [3:0] OP_SHIFT_REG = 4'hC;
  localparam logic [3:0] OP_SHIFT_IMM = 4'hD;
  localparam logic [3:0] OP_BRANCH = 4'hF;
  localparam logic [1:0] SHIFT_LEFT_LOW = 2'h1;
  localparam logic [1:0] SHIFT_RIGHT_LOW = 2'h2;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_DWORD = 2'h3;
  localparam logic [3:0] BR_CARRY_CLEAR = 4'h0;
  localparam logic [3:0] BR_CARRY_SET = 4'h1;
  localparam logic [3:0] BR_ZERO = 4'h3;
  localparam logic [3:0] BR_ABOVE_UNS = 4'h8;
  localparam logic [3:0] BR_SIGNED_GE = 4'hA;
  localparam logic [3:0] BR_SIGNED_GT = 4'hC;
  // Cycle counts
  localparam logic [5:0] CYC_SHIFT_BASE = 6'h04;
  localparam logic [5:0] CYC_SHIFT_DW_BASE = 6'h06;
  localparam logic [5:0] CYC_BR_TAKEN = 6'h06;
  localparam logic [5:0] CYC_BR_NOT = 6'h03;
  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam logic [31:0] RESET_OPND = 32'h0000_0000;
  localparam logic [23:0] RESET_PC = 24'h000000;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_WAIT} asb_state_t;
  // Carry in bit 0, in step with the FLG_ positions
  typedef struct packed {
    logic z;
    logic n;
    logic v;
    logic c;
  } asb_flags_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } asb_bus_out_t;
endpackage

// >>> core/asb_shift_step.sv
// Purpose: One bit of arithmetic shift for byte, word or double word
// Assumes: Size code already decoded from the size field
// Notes: Purely combinational; the main unit chains two copies, two steps per cycle
`timescale 1ns/1ps
module asb_shift_step
  import asb_pkg::*;
(
  // Operand in
  input wire logic [31:0] val,
  input wire logic [1:0] size,
  input wire logic left,
  // Result
  output logic [31:0] res,
  output logic cout,
  output logic sign_chg
);
  logic msb_in;
  logic msb_out;
  always_comb begin
    case (size)
      SZ_BYTE: msb_in = val[7];
      SZ_WORD: msb_in = val[15];
      default: msb_in = val[31];
    endcase
    if (left) begin
      res = {val[30:0], 1'b0};
      cout = msb_in;
    end else begin
      res = {1'b0, val[31:1]};
      cout = val[0];
      case (size)
        SZ_BYTE: res[7] = val[7];
        SZ_WORD: res[15] = val[15];
        default: res[31] = val[31];
      endcase
    end
    case (size)
      SZ_BYTE: msb_out = res[7];
      SZ_WORD: msb_out = res[15];
      default: msb_out = res[31];
    endcase
    sign_chg = left & (msb_out ^ msb_in);
  end
endmodule // asb_shift_step

// >>> core/asb_branch_cond.sv
// Purpose: Condition evaluation for relative branches
// Assumes: Flags are those left by the last flag-writing instruction
// Notes: Unknown condition codes evaluate as not taken
`timescale 1ns/1ps
module asb_branch_cond
  import asb_pkg::*;
(
  // Condition and flags
  input wire logic [3:0] cond,
  input wire asb_flags_t flags,
  // Decision
  output logic taken,
  output logic known
);
  always_comb begin
    known = 1'b1;
    case (cond)
      BR_CARRY_CLEAR: taken = ~flags.c;
      BR_CARRY_SET: taken = flags.c;
      BR_ZERO: taken = flags.z;
      BR_ABOVE_UNS: taken = ~(flags.z | flags.c);
      BR_SIGNED_GE: taken = ~(flags.n ^ flags.v);
      BR_SIGNED_GT: taken = ~((flags.z | flags.n) ^ flags.v);
      default: begin
        taken = 1'b0;
        known = 1'b0;
      end
    endcase
  end
endmodule // asb_branch_cond

// >>> testbench/asb_unit_assertions.sv
// Purpose: Port checker for asb_unit
// Assumes: One clock, async active-low reset
// Notes: Longest run is a 31-step double word shift
`timescale 1ns/1ps
module asb_unit_assertions
  import asb_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Status
  input wire logic busy,
  input wire logic done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_go;
    avs_write && !avs_waitrequest && avs_address == OFS_CTRL && avs_writedata[CTRL_GO_BIT] && !busy;
  endsequence
  sequence s_start;
    $rose(busy);
  endsequence
  a_go_busy: assert property (s_go |=> busy) else $error("go did not start a run");
  a_run_min: assert property (s_start |-> busy [*3]) else $error("run too short");
  a_run_max: assert property (s_start |-> ##[3:21] done) else $error("run too long");
  a_done_end: assert property (done |-> !busy && $past(busy)) else $error("done outside run end");
  a_fall_done: assert property ($fell(busy) |-> done) else $error("run ended without done");
  a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
  a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer timing");
  a_write_wait: assert property (avs_write && avs_waitrequest |=> !avs_waitrequest) else $error("write not answered");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule // asb_unit_assertions

bind asb_unit asb_unit_assertions u_chk (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .busy, .done);

// >>> testbench/arith_shift_and_cond_branch_test.sv
// Purpose: Self-checking bench for asb_unit
// Assumes: Master waits on waitrequest, bounded by a timeout
// Notes: Rows hold ordinary cases; refused write and mid-run reset follow
`timescale 1ns/1ps
module arith_shift_and_cond_branch_test
  import asb_pkg::*;
;
  typedef struct {
    logic [15:0] insn;
    logic [31:0] op;
    logic [31:0] cnt;
    logic [3:0] fl;
    logic [31:0] eo;
    logic [3:0] ef;
    int ec;
  } asb_row_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic busy;
  logic done;
  logic [31:0] q;
  int error_cnt = 0;
  int compares = 0;
  // Flags column is {Z,N,V,C}; branch rows carry the PC in op
  asb_row_t rows [20] = '{
    '{16'hC100, 32'h40, 32'h1, 4'h0, 32'h80, 4'h6, 4},
    '{16'hC100, 32'h40, 32'h22, 4'h0, 32'h0, 4'hB, 5},
    '{16'hC900, 32'h11, 32'h3, 4'h3, 32'h88, 4'h0, 5},
    '{16'hDD11, 32'h1, 32'h0, 4'h0, 32'h20000, 4'h0, 14},
    '{16'hCA00, 32'h8003, 32'h1, 4'h2, 32'hC001, 4'h7, 4},
    '{16'hDE1F, 32'h80000000, 32'h0, 4'h0, 32'hFFFFFFFF, 4'h4, 21},
    '{16'hD213, 32'h81, 32'h0, 4'h0, 32'hF0, 4'h4, 5},
    '{16'hC200, 32'h5A, 32'h0, 4'hB, 32'h5A, 4'h3, 4},
    '{16'hF07F, 32'h1000, 32'h0, 4'h0, 32'h1100, 4'h0, 6},
    '{16'hF07F, 32'h1000, 32'h0, 4'h1, 32'h1002, 4'h1, 3},
    '{16'hF180, 32'h1000, 32'h0, 4'h1, 32'hF02, 4'h1, 6},
    '{16'hF301, 32'h1001, 32'h0, 4'h8, 32'h1004, 4'h8, 6},
    '{16'hF301, 32'h1000, 32'h0, 4'h0, 32'h1002, 4'h0, 3},
    '{16'hF802, 32'h1000, 32'h0, 4'h0, 32'h1006, 4'h0, 6},
    '{16'hF802, 32'h1000, 32'h0, 4'h1, 32'h1002, 4'h1, 3},
    '{16'hFAFF, 32'h1000, 32'h0, 4'h6, 32'h1000, 4'h6, 6},
    '{16'hFAFF, 32'h1000, 32'h0, 4'h4, 32'h1002, 4'h4, 3},
    '{16'hFC10, 32'h1000, 32'h0, 4'h0, 32'h1022, 4'h0, 6},
    '{16'hFC10, 32'h1000, 32'h0, 4'h8, 32'h1002, 4'h8, 3},
    '{16'hFC10, 32'h1000, 32'h0, 4'hA, 32'h1022, 4'hA, 6}
  };
  asb_unit DUT (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy), .done(done));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One idle edge before each request; held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 20) begin
      error_cnt++;
      conclude();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic start(input asb_row_t r);
    bus(1'b1, OFS_OPND, r.op);
    bus(1'b1, OFS_CNT, r.cnt);
    bus(1'b1, OFS_INSN, {r.op[15:0], r.insn});
    bus(1'b1, OFS_CTRL, {12'h0, r.fl, 16'h1});
  endtask
  task automatic finish(input asb_row_t r, input bit cyc);
    int n;
    int k;
    logic br;
    n = 0;
    br = (r.insn[15:12] == OP_BRANCH);
    for (k = 0; k < 60 && !(n > 0 && busy === 1'b0); k++) begin
      @(negedge sys_clk);
      if (busy === 1'b1)
        n++;
    end
    if (k == 60) begin
      error_cnt++;
      conclude();
    end
    chk("done", done, 1'b1);
    if (cyc)
      chk("cycles", n, r.ec);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("flags", q[19:16], r.ef);
    if (br)
      chk("taken", q[STAT_TAKEN_BIT], r.ec == 6);
    bus(1'b0, br ? OFS_INSN : OFS_OPND, 32'h0);
    chk("result", br ? {8'h0, q[23:0]} : q, r.eo);
    if (!br) begin
      bus(1'b0, OFS_CNT, 32'h0);
      chk("count reg", q, r.cnt);
    end
    $display("test %h done", r.insn);
  endtask
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    bus(1'b0, OFS_STAT, 32'h0);
    chk("reset stat", q, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    foreach (rows[i]) begin
      start(rows[i]);
      finish(rows[i], 1'b1);
    end
    // Operand write during a run must be ignored
    start(rows[5]);
    bus(1'b1, OFS_OPND, 32'h0);
    finish(rows[5], 1'b0);
    // Reset in mid-run must stop it at once
    start(rows[5]);
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk("busy after reset", busy, 1'b0);
    chk("done after reset", done, 1'b0);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("stat after reset", q, 32'h0);
    $display("test mid-run reset done");
    // The unit must run normally again after the cut
    start(rows[0]);
    finish(rows[0], 1'b1);
    conclude();
  end
endmodule // arith_shift_and_cond_branch_test
